// file: dac_seq_pkg.sv
// Notes on behaviour
// - each channel holds a first and a second stage; outputs move together.
// - address all ones, either even/odd level: load starts after sequence begin.
// - a strobe high at a pin-clock fall copies all first stages to second.
// - direction low fills channels 0 up to 5, high fills 5 down to 0.
// - in sequential load, even/odd high captures on rising pin-clock edges, low on falling ones.
// - even device takes even words, odd device odd words, in chosen order.
// - begin and strobe held high write the addressed channel at each fall.
// - an addressed word lands at a fall in the channel addressed at the rise.
// - addressed writes leave outputs alone until a strobe releases them all.
// - low power request clears all stored data; operation resumes after.
package dac_seq_pkg;
    localparam int NUM_CHANNELS = 6;
    localparam int WORD_WIDTH = 10;
    localparam logic [2:0] ADDR_SEQUENTIAL = 3'h7;
    localparam logic [2:0] ADDR_NO_CHANNEL = 3'h6;
    localparam logic [2:0] CHAN_FIRST = 3'h0;
    localparam logic [2:0] CHAN_LAST = 3'h5;
    localparam logic [2:0] SEQ_LAST_COUNT = 3'h5;
    localparam logic [9:0] CODE_RESET = 10'h000;

    // pins driven by the display timing controller
    typedef struct packed {
        logic pin_clk;
        logic even_odd;
        logic right_left;
        logic [2:0] addr;
        logic sequence_begin;
        logic output_transfer_strobe;
        logic low_power_request;
    } ctrl_t;

    typedef logic [NUM_CHANNELS-1:0][WORD_WIDTH-1:0] chan_codes_t;
endpackage : dac_seq_pkg

// file: dac_latch_pair.sv
`timescale 1ns/100ps
`default_nettype none
module dac_latch_pair
    import dac_seq_pkg::*;
#(
    parameter int WIDTH = WORD_WIDTH
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clear_in,
    input wire logic load_in,
    input wire logic xfer_in,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] master_out,
    output logic [WIDTH-1:0] slave_out
);
    logic [WIDTH-1:0] master_ff;
    logic [WIDTH-1:0] slave_ff;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            master_ff <= '0;
        end else if (clear_in) begin
            master_ff <= '0;
        end else if (load_in) begin
            master_ff <= data_in;
        end
    end

    // a load and a transfer on one edge pass the new word straight through
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slave_ff <= '0;
        end else if (clear_in) begin
            slave_ff <= '0;
        end else if (xfer_in) begin
            slave_ff <= load_in ? data_in : master_ff;
        end
    end

    assign master_out = master_ff;
    assign slave_out = slave_ff;
endmodule : dac_latch_pair
`default_nettype wire

// file: dac_load_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module dac_load_sequencer
    import dac_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire ctrl_t ctrl_in,
    input wire logic [WORD_WIDTH-1:0] word_in,
    output chan_codes_t channel_output_out,
    output logic sequence_busy_out
);
    // ------------------------------------------------------------
    // pin clock edges and mode decode
    // ------------------------------------------------------------
    logic pin_clk_ff;
    logic seq_begin_prev_ff;
    logic [2:0] addr_ff;
    logic pin_rise;
    logic pin_fall;
    logic seq_mode;
    logic standby;
    logic start;
    logic capture_edge;

    assign pin_rise = ctrl_in.pin_clk && !pin_clk_ff;
    assign pin_fall = !ctrl_in.pin_clk && pin_clk_ff;
    assign seq_mode = (ctrl_in.addr == ADDR_SEQUENTIAL);
    assign standby = ctrl_in.low_power_request;
    assign start = seq_mode && ctrl_in.sequence_begin && !seq_begin_prev_ff;
    assign capture_edge = ctrl_in.even_odd ? pin_rise : pin_fall;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_clk_ff <= 1'b0;
            seq_begin_prev_ff <= 1'b0;
        end else begin
            pin_clk_ff <= ctrl_in.pin_clk;
            seq_begin_prev_ff <= ctrl_in.sequence_begin;
        end
    end

    // address is taken at the rising edge and used at the next fall
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr_ff <= ADDR_NO_CHANNEL;
        end else if (pin_rise) begin
            addr_ff <= ctrl_in.addr;
        end
    end

    // ------------------------------------------------------------
    // sequential loader
    // ------------------------------------------------------------
    logic seq_active_ff;
    logic dir_ff;
    logic [2:0] seq_idx_ff;
    logic [2:0] seq_cnt_ff;
    logic seq_wr;

    assign seq_wr = seq_active_ff && capture_edge && !start && !standby;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seq_active_ff <= 1'b0;
            dir_ff <= 1'b0;
            seq_idx_ff <= CHAN_FIRST;
            seq_cnt_ff <= 3'h0;
        end else if (standby) begin
            seq_active_ff <= 1'b0;
            seq_cnt_ff <= 3'h0;
        end else if (start) begin
            seq_active_ff <= 1'b1;
            dir_ff <= ctrl_in.right_left;
            seq_idx_ff <= ctrl_in.right_left ? CHAN_LAST : CHAN_FIRST;
            seq_cnt_ff <= 3'h0;
        end else if (seq_wr) begin
            seq_cnt_ff <= seq_cnt_ff + 3'h1;
            seq_idx_ff <= dir_ff ? seq_idx_ff - 3'h1
                : seq_idx_ff + 3'h1;
            if (seq_cnt_ff == SEQ_LAST_COUNT) begin
                seq_active_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sequence_busy_out <= 1'b0;
        end else begin
            sequence_busy_out <= seq_active_ff;
        end
    end

    // ------------------------------------------------------------
    // addressed and direct writes, transfer
    // ------------------------------------------------------------
    logic addr_wr;
    logic xfer;
    logic [NUM_CHANNELS-1:0] load;
    chan_codes_t masters;

    // code 6 and code 7 never reach a channel here
    assign addr_wr = !seq_mode && pin_fall && ctrl_in.sequence_begin
        && (addr_ff < ADDR_NO_CHANNEL) && !standby;
    assign xfer = pin_fall && ctrl_in.output_transfer_strobe;

    for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
        assign load[i] = (seq_wr && seq_idx_ff == 3'(i))
            || (addr_wr && addr_ff == 3'(i));
        dac_latch_pair #(
            .WIDTH(WORD_WIDTH)
        ) u_latch (
            .clk_in(clk_in),
            .arst_n_in(arst_n_in),
            .clear_in(standby),
            .load_in(load[i]),
            .xfer_in(xfer),
            .data_in(word_in),
            .master_out(masters[i]),
            .slave_out(channel_output_out[i])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    property p_outputs_move_together;
        !xfer && !standby |=> $stable(channel_output_out);
    endproperty
    a_outputs_move_together: assert property (p_outputs_move_together)
        else $error("outputs changed without a transfer");

    property p_start_arms;
        start && !standby |=> seq_active_ff && seq_cnt_ff == 3'h0;
    endproperty
    a_start_arms: assert property (p_start_arms)
        else $error("sequence did not arm on start");

    property p_transfer_copies;
        xfer && !standby && load == '0
            |=> channel_output_out == $past(masters);
    endproperty
    a_transfer_copies: assert property (p_transfer_copies)
        else $error("transfer did not copy first stages");

    property p_ascending;
        seq_wr && !dir_ff |=> seq_idx_ff == $past(seq_idx_ff) + 3'h1;
    endproperty
    a_ascending: assert property (p_ascending)
        else $error("ascending order broken");

    property p_descending;
        seq_wr && dir_ff |=> seq_idx_ff == $past(seq_idx_ff) - 3'h1;
    endproperty
    a_descending: assert property (p_descending)
        else $error("descending order broken");

    property p_capture_edge;
        seq_wr |-> ctrl_in.pin_clk == ctrl_in.even_odd
            && $past(ctrl_in.pin_clk) != ctrl_in.even_odd;
    endproperty
    a_capture_edge: assert property (p_capture_edge)
        else $error("word captured on wrong pin edge");

    property p_addressed_write;
        addr_wr |=> masters[$past(addr_ff)] == $past(word_in);
    endproperty
    a_addressed_write: assert property (p_addressed_write)
        else $error("addressed word not stored");

    property p_addressed_held;
        addr_wr && !ctrl_in.output_transfer_strobe
            |=> $stable(channel_output_out);
    endproperty
    a_addressed_held: assert property (p_addressed_held)
        else $error("output moved on addressed write");

    property p_standby_clears;
        standby
            |=> channel_output_out == '0 && masters == '0 && !seq_active_ff;
    endproperty
    a_standby_clears: assert property (p_standby_clears)
        else $error("standby did not clear state");

    property p_code6_idle;
        !seq_active_ff && addr_ff == ADDR_NO_CHANNEL && !standby
            |=> $stable(masters);
    endproperty
    a_code6_idle: assert property (p_code6_idle)
        else $error("code 6 changed a channel");

    property p_stop_after_six;
        seq_wr && seq_cnt_ff == SEQ_LAST_COUNT
            |=> !seq_active_ff ##1 (!seq_active_ff || $past(start));
    endproperty
    a_stop_after_six: assert property (p_stop_after_six)
        else $error("sequencer ran past six words");

    property p_start_no_capture;
        start && !standby |=> $stable(masters);
    endproperty
    a_start_no_capture: assert property (p_start_no_capture)
        else $error("start edge captured a word");

    property p_direct_through;
        addr_wr && xfer
            |=> channel_output_out[$past(addr_ff)] == $past(word_in);
    endproperty
    a_direct_through: assert property (p_direct_through)
        else $error("direct word did not reach its output");

    property p_busy_follows;
        sequence_busy_out == $past(seq_active_ff);
    endproperty
    a_busy_follows: assert property (p_busy_follows)
        else $error("busy flag does not follow the sequencer");

    c_full_sequence: cover property (seq_wr && seq_cnt_ff == SEQ_LAST_COUNT);
    c_reverse_sequence: cover property (seq_wr && dir_ff
        && seq_idx_ff == 3'h0);
    c_direct_load: cover property (addr_wr && xfer);
    c_addressed_transfer: cover property (addr_wr ##[1:20] xfer);
    c_standby: cover property (standby && seq_active_ff);
endmodule : dac_load_sequencer
`default_nettype wire

// file: timing_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// display timing controller model
// ----------------------------------------
module timing_ctrl_model
    import dac_seq_pkg::*;
(
    input wire logic clk_in,
    output ctrl_t ctrl_out,
    output logic [WORD_WIDTH-1:0] word_out
);
    initial begin
        ctrl_out = '0;
        word_out = '0;
    end
    // this device gets its own sequence begin
    task cfg(input logic eo, rl, input logic [2:0] a,
             input logic sb, xf, lp);
        @(posedge clk_in);
        ctrl_out.even_odd <= eo;
        ctrl_out.right_left <= rl;
        ctrl_out.addr <= a;
        ctrl_out.sequence_begin <= sb;
        ctrl_out.output_transfer_strobe <= xf;
        ctrl_out.low_power_request <= lp;
    endtask : cfg
    // one pin clock level for three cycles, word valid at its edge only
    task pin(input logic lvl, input logic [WORD_WIDTH-1:0] w);
        @(posedge clk_in);
        ctrl_out.pin_clk <= lvl;
        word_out <= w;
        @(posedge clk_in);
        word_out <= ~w;
        @(posedge clk_in);
    endtask : pin
endmodule : timing_ctrl_model
`default_nettype wire

// file: six_channel_dac_load_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module six_channel_dac_load_sequencer_bench;
    import dac_seq_pkg::*;
    logic clk_in;
    logic arst_n_in;
    ctrl_t ctrl;
    logic [WORD_WIDTH-1:0] word;
    chan_codes_t outs;
    chan_codes_t cur;
    chan_codes_t stage;
    logic busy;
    int failures;
    int cmp_count;
    dac_load_sequencer u_dac_load_sequencer (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .ctrl_in(ctrl), .word_in(word),
        .channel_output_out(outs), .sequence_busy_out(busy));
    timing_ctrl_model u_timing_ctrl_model (.clk_in(clk_in),
        .ctrl_out(ctrl), .word_out(word));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task chk(input logic [59:0] seen, input logic [59:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task end_of_test;
        $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    // six words, a seventh ignored, then a transfer fall
    task seq(input logic eo, rl, input logic [9:0] base);
        int i;
        u_timing_ctrl_model.cfg(eo, rl, 3'h7, 1'b0, 1'b0, 1'b0);
        u_timing_ctrl_model.cfg(eo, rl, 3'h7, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 8 && busy !== 1'b1; i++) @(posedge clk_in);
        if (busy !== 1'b1) begin
            failures++;
            end_of_test();
        end
        for (i = 0; i < 7; i++) begin
            u_timing_ctrl_model.pin(1'b1, eo ? base + 10'(i) : 10'h3FF);
            u_timing_ctrl_model.pin(1'b0, eo ? 10'h3FF : base + 10'(i));
            if (i < 6) stage[rl ? 5 - i : i] = base + 10'(i);
        end
        @(negedge clk_in);
        chk(outs, cur);
        chk(busy, 1'b0);
        u_timing_ctrl_model.cfg(eo, rl, 3'h7, 1'b1, 1'b1, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.pin(1'b0, 10'h000);
        @(negedge clk_in);
        cur = stage;
        chk(outs, cur);
    endtask : seq
    initial begin
        int m;
        failures = 0;
        cmp_count = 0;
        cur = '0;
        stage = '0;
        arst_n_in = 1'b0;
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        chk(outs, cur);
        for (m = 0; m < 4; m++) seq(m[1], m[0], 10'h100 + 10'(m * 64));
        // addressed: code 6 writes nothing, address taken at the rise
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h6, 1'b1, 1'b0, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.pin(1'b0, 10'h155);
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0);
        u_timing_ctrl_model.pin(1'b0, 10'h2AA);
        stage[1] = 10'h2AA;
        @(negedge clk_in);
        chk(outs, cur);
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h6, 1'b1, 1'b1, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.pin(1'b0, 10'h000);
        @(negedge clk_in);
        cur = stage;
        chk(outs, cur);
        // direct load through to the output
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h2, 1'b1, 1'b1, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.pin(1'b0, 10'h0F3);
        @(negedge clk_in);
        cur[2] = 10'h0F3;
        chk(outs, cur);
        // standby clears, then loading resumes
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h2, 1'b1, 1'b1, 1'b1);
        repeat (2) @(negedge clk_in);
        chk(outs, '0);
        u_timing_ctrl_model.cfg(1'b1, 1'b0, 3'h2, 1'b1, 1'b1, 1'b0);
        u_timing_ctrl_model.pin(1'b1, 10'h000);
        u_timing_ctrl_model.pin(1'b0, 10'h01C);
        @(negedge clk_in);
        cur = '0;
        cur[2] = 10'h01C;
        chk(outs, cur);
        end_of_test();
    end
endmodule : six_channel_dac_load_sequencer_bench
`default_nettype wire
